// ---- common/ucf_consts.vh ----
// Constants for the serial transceiver clock, frame and receive buffer block.
// Assumes an 8-bit register port with a 3-bit word index.
`ifndef UCF_CONSTS_VH
`define UCF_CONSTS_VH

// Register indices
`define UCF_ADDR_DATA   3'h0
`define UCF_ADDR_CSA    3'h1
`define UCF_ADDR_CSB    3'h2
`define UCF_ADDR_CSC    3'h3
`define UCF_ADDR_BAUDL  3'h4
`define UCF_ADDR_BAUDH  3'h5

// ctrl_status_a fields
`define UCF_A_RXC       7
`define UCF_A_TXE       5
`define UCF_A_FE        4
`define UCF_A_DOR       3
`define UCF_A_PE        2
`define UCF_A_U2X       1

// ctrl_status_b fields
`define UCF_B_RXEN      4
`define UCF_B_TXEN      3
`define UCF_B_CSZ2      2
`define UCF_B_RX9       1
`define UCF_B_TX9       0

// ctrl_status_c fields
`define UCF_C_DIR       7
`define UCF_C_SYNC      6
`define UCF_C_PM_HI     5
`define UCF_C_PM_LO     4
`define UCF_C_SBS       3
`define UCF_C_CSZ_HI    2
`define UCF_C_CSZ_LO    1
`define UCF_C_POL       0

// Reset values
`define UCF_RST_CHAR_SIZE 3'h3
`define UCF_RST_PARITY    2'h0
`define UCF_RST_DIVISOR   12'h000

// Receive entry layout
`define UCF_E_DOR       11
`define UCF_E_FE        10
`define UCF_E_PE        9
`define UCF_E_D9        8

// Ticks of the baud generator per bit
`define UCF_SPB_NORMAL  5'h10
`define UCF_SPB_DOUBLE  5'h08

`endif

// ---- logic/ucf_usart_clk_frame.v ----
// Clock generation, frame formatting and receive buffering of a serial transceiver.
// Assumes registers written over a single-cycle strobe port on sys_clk; pins are asynchronous.
//
// Functional notes
// - Received characters go through a two-entry circular FIFO; each data read pops one.
// - Frame, overrun and ninth-bit status travel with each entry; read status first.
// - With FIFO full, a finished character waits in the shift register until next start.
// - Four clock modes; sync select picks sync or async, double speed is async only.
// - In sync mode the pin direction bit picks master clock out or slave clock in.
// - Baud counter on system clock reloads at zero and on low divisor byte write.
// - Baud generator pulses once per counter zero, rate system clock over divisor plus one.
// - Transmit bit rate is baud output over 16, 8 or 2 by mode.
// - Receiver recovery steps through 2, 8 or 16 states per bit by mode bits.
// - Divisor is high and low registers joined, 0 to 4095.
// - Double speed halves async divisor, ignored in sync; software keeps it zero there.
// - Double speed receiver uses 8 samples per bit instead of 16.
// - Slave clock passes a synchroniser then edge detector, two cycles of delay.
// - Sync receive samples on the edge opposite the transmit change edge.
// - Polarity 0 changes on rising and samples falling; polarity 1 the reverse.
// - Frames: one start, 5 to 9 data bits, none/even/odd parity, 1 or 2 stops.
// - Start, data LSB first, optional parity, stops; next frame may follow directly.
// - Start is low, stops high, idle line high.
// - One frame format setting is shared by receiver and transmitter.
// - Receiver checks only the first stop bit; zero there is a frame error.
// - Parity is XOR of data bits for even, inverted for odd.
//
// Added by the designer: the address map and the plain strobed port.
`include "ucf_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ucf_usart_clk_frame #(
	parameter FIFO_AW = 1
) (
	input  wire       sys_clk,
	input  wire       rst_b,
	input  wire [2:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       rxd_pin,
	output reg        txd_pin,
	input  wire       xfer_clock_pin_in,
	output reg        xfer_clock_pin_out,
	output wire       xfer_clock_pin_oe_n
);

	localparam RX_IDLE  = 3'd0;
	localparam RX_START = 3'd1;
	localparam RX_DATA  = 3'd2;
	localparam RX_PAR   = 3'd3;
	localparam RX_STOP  = 3'd4;

	// Control fields
	reg        double_speed;
	reg        rx_enable;
	reg        tx_enable;
	reg        tx_ninth_bit;
	reg  [2:0] char_size;
	reg  [1:0] parity_mode;
	reg        stop_bits_select;
	reg        sync_mode_select;
	reg        xfer_clock_pin_direction;
	reg        clock_polarity;
	reg  [3:0] baud_divisor_high;
	reg  [7:0] baud_divisor_low;

	wire wr_data  = reg_wr & (reg_addr == `UCF_ADDR_DATA);
	wire wr_csa   = reg_wr & (reg_addr == `UCF_ADDR_CSA);
	wire wr_csb   = reg_wr & (reg_addr == `UCF_ADDR_CSB);
	wire wr_csc   = reg_wr & (reg_addr == `UCF_ADDR_CSC);
	wire wr_baudl = reg_wr & (reg_addr == `UCF_ADDR_BAUDL);
	wire wr_baudh = reg_wr & (reg_addr == `UCF_ADDR_BAUDH);
	wire rd_data  = reg_rd & (reg_addr == `UCF_ADDR_DATA);

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			double_speed             <= 1'b0;
			rx_enable                <= 1'b0;
			tx_enable                <= 1'b0;
			tx_ninth_bit             <= 1'b0;
			char_size                <= `UCF_RST_CHAR_SIZE;
			parity_mode              <= `UCF_RST_PARITY;
			stop_bits_select         <= 1'b0;
			sync_mode_select         <= 1'b0;
			xfer_clock_pin_direction <= 1'b0;
			clock_polarity           <= 1'b0;
			baud_divisor_high        <= 4'h0;
			baud_divisor_low         <= 8'h00;
		end else begin
			if (wr_csa)
				double_speed <= reg_wdata[`UCF_A_U2X];
			if (wr_csb) begin
				rx_enable    <= reg_wdata[`UCF_B_RXEN];
				tx_enable    <= reg_wdata[`UCF_B_TXEN];
				char_size[2] <= reg_wdata[`UCF_B_CSZ2];
				tx_ninth_bit <= reg_wdata[`UCF_B_TX9];
			end
			if (wr_csc) begin
				xfer_clock_pin_direction <= reg_wdata[`UCF_C_DIR];
				sync_mode_select         <= reg_wdata[`UCF_C_SYNC];
				parity_mode              <= reg_wdata[`UCF_C_PM_HI:`UCF_C_PM_LO];
				stop_bits_select         <= reg_wdata[`UCF_C_SBS];
				char_size[1:0]           <= reg_wdata[`UCF_C_CSZ_HI:`UCF_C_CSZ_LO];
				clock_polarity           <= reg_wdata[`UCF_C_POL];
			end
			if (wr_baudl)
				baud_divisor_low <= reg_wdata;
			if (wr_baudh)
				baud_divisor_high <= reg_wdata[3:0];
		end
	end

	// Baud generator
	wire [11:0] baud_divisor = {baud_divisor_high, baud_divisor_low};
	reg  [11:0] baud_cnt;
	wire        baud_tick = (baud_cnt == 12'h000);

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			baud_cnt <= `UCF_RST_DIVISOR;
		else if (wr_baudl)
			baud_cnt <= {baud_divisor_high, reg_wdata};
		else if (baud_tick)
			baud_cnt <= baud_divisor;
		else
			baud_cnt <= baud_cnt - 12'h001;
	end

	// Mode decode
	wire       sync_master = sync_mode_select & xfer_clock_pin_direction;
	wire       sync_slave  = sync_mode_select & ~xfer_clock_pin_direction;
	wire       dbl         = double_speed & ~sync_mode_select;
	wire [4:0] spb         = dbl ? `UCF_SPB_DOUBLE : `UCF_SPB_NORMAL;
	wire [4:0] spb_half    = {1'b0, spb[4:1]};

	assign xfer_clock_pin_oe_n = ~sync_master;

	// Pin synchronisers; the third clock stage is the slave edge detector
	reg rxd_meta;
	reg rxd_sync;
	reg xck_meta;
	reg xck_sync;
	reg xck_last;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			xck_meta <= 1'b0;
			xck_sync <= 1'b0;
			xck_last <= 1'b0;
		end else begin
			rxd_meta <= rxd_pin;
			rxd_sync <= rxd_meta;
			xck_meta <= xfer_clock_pin_in;
			xck_sync <= xck_meta;
			xck_last <= xck_sync;
		end
	end

	wire xck_rise = xck_sync & ~xck_last;
	wire xck_fall = ~xck_sync & xck_last;

	// Master clock toggles on every tick, so one period is two ticks
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			xfer_clock_pin_out <= 1'b0;
		else if (!sync_master)
			xfer_clock_pin_out <= clock_polarity;
		else if (baud_tick)
			xfer_clock_pin_out <= ~xfer_clock_pin_out;
	end

	// Leaving the idle level is the change edge: rising for polarity 0
	wire m_change = baud_tick & (xfer_clock_pin_out == clock_polarity);
	wire m_sample = baud_tick & (xfer_clock_pin_out != clock_polarity);
	wire s_change = clock_polarity ? xck_fall : xck_rise;
	wire s_sample = clock_polarity ? xck_rise : xck_fall;
	wire sync_samp = sync_master ? m_sample : s_sample;

	// Transmit prescaler
	reg  [3:0] tx_pre;
	wire       tx_pre_wrap = ({1'b0, tx_pre} == (spb - 5'h01));
	wire       tx_bit_en = sync_master ? m_change : (sync_slave ? s_change : (baud_tick & tx_pre_wrap));

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			tx_pre <= 4'h0;
		else if (baud_tick)
			tx_pre <= tx_pre_wrap ? 4'h0 : tx_pre + 4'h1;
	end

	// Shared frame format
	reg  [3:0] nbits;
	wire       par_en  = parity_mode[1];
	wire       par_odd = parity_mode[0];

	always @* begin
		case (char_size)
			3'h0:    nbits = 4'd5;
			3'h1:    nbits = 4'd6;
			3'h2:    nbits = 4'd7;
			3'h7:    nbits = 4'd9;
			default: nbits = 4'd8;
		endcase
	end

	// Transmit buffer and frame assembly
	reg  [8:0]  tx_buf;
	reg         tx_full;
	reg  [12:0] tx_sh;
	reg  [3:0]  tx_left;
	wire [8:0]  tx_mask = 9'h1ff >> (4'd9 - nbits);
	wire        tx_par  = (^(tx_buf & tx_mask)) ^ par_odd;
	wire [3:0]  tx_len  = 4'd2 + nbits + {3'b000, par_en} + {3'b000, stop_bits_select};
	wire [12:0] tx_frame;
	wire        tx_load = tx_enable & tx_bit_en & (tx_left <= 4'h1) & tx_full;

	genvar gi;
	generate
		for (gi = 0; gi < 13; gi = gi + 1) begin : g_frame
			localparam [3:0] IDX = gi;
			if (gi == 0) begin : g_start
				assign tx_frame[gi] = 1'b0;
			end else begin : g_body
				assign tx_frame[gi] = (IDX <= nbits) ? tx_buf[gi-1] :
					((par_en && IDX == nbits + 4'd1) ? tx_par : 1'b1);
			end
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_buf  <= 9'h000;
			tx_full <= 1'b0;
			tx_sh   <= 13'h1fff;
			tx_left <= 4'h0;
			txd_pin <= 1'b1;
		end else begin
			if (wr_data)
				tx_buf <= {tx_ninth_bit, reg_wdata};
			tx_full <= wr_data | (tx_full & ~tx_load);
			if (!tx_enable) begin
				tx_left <= 4'h0;
				txd_pin <= 1'b1;
			end else if (tx_bit_en) begin
				if (tx_left > 4'h1) begin
					tx_sh   <= {1'b1, tx_sh[12:1]};
					txd_pin <= tx_sh[1];
					tx_left <= tx_left - 4'h1;
				end else if (tx_full) begin
					tx_sh   <= tx_frame;
					txd_pin <= tx_frame[0];
					tx_left <= tx_len;
				end else begin
					tx_left <= 4'h0;
					txd_pin <= 1'b1;
				end
			end
		end
	end

	// Receive FIFO
	localparam DEPTH = 1 << FIFO_AW;
	reg  [11:0]      fifo_mem [0:DEPTH-1];
	reg  [FIFO_AW-1:0] fifo_wp;
	reg  [FIFO_AW-1:0] fifo_rp;
	reg  [FIFO_AW:0]   fifo_cnt;
	wire fifo_full  = (fifo_cnt == DEPTH[FIFO_AW:0]);
	wire fifo_empty = (fifo_cnt == {(FIFO_AW+1){1'b0}});
	wire [11:0] head = fifo_empty ? 12'h000 : fifo_mem[fifo_rp];

	// Receiver
	reg  [2:0] rx_state;
	reg  [3:0] rx_cnt;
	reg  [3:0] rx_bitn;
	reg  [8:0] rx_sh;
	reg        rx_par;
	reg        rx_perr;
	reg        rx_fe;
	reg        rx_pend;
	reg        ovr_flag;
	wire       rx_mid   = ({1'b0, rx_cnt} == (spb_half - 5'h01));
	wire       rx_samp  = sync_mode_select ? sync_samp : (baud_tick & rx_mid);
	wire       rx_start = rx_enable & (rx_state == RX_IDLE) & ~rxd_sync &
		(sync_mode_select ? sync_samp : baud_tick);
	wire       rx_drop  = rx_start & rx_pend & fifo_full;
	wire       rx_push  = rx_pend & ~fifo_full;
	wire       rx_done  = rx_enable & (rx_state == RX_STOP) & rx_samp;
	wire [8:0] rx_data  = rx_sh >> (4'd9 - nbits);
	wire       rx_pop   = rd_data & ~fifo_empty;

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state <= RX_IDLE;
			rx_cnt   <= 4'h0;
			rx_bitn  <= 4'h0;
			rx_sh    <= 9'h000;
			rx_par   <= 1'b0;
			rx_perr  <= 1'b0;
			rx_fe    <= 1'b0;
		end else if (!rx_enable) begin
			rx_state <= RX_IDLE;
		end else begin
			if (rx_state != RX_IDLE && baud_tick)
				rx_cnt <= ({1'b0, rx_cnt} == (spb - 5'h01)) ? 4'h0 : rx_cnt + 4'h1;
			case (rx_state)
				RX_IDLE: begin
					if (rx_start) begin
						rx_cnt   <= 4'h0;
						rx_bitn  <= 4'h0;
						rx_par   <= 1'b0;
						rx_state <= sync_mode_select ? RX_DATA : RX_START;
					end
				end
				RX_START: begin
					// A glitch shorter than half a bit is a false start
					if (rx_samp)
						rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rx_samp) begin
						rx_sh   <= {rxd_sync, rx_sh[8:1]};
						rx_par  <= rx_par ^ rxd_sync;
						rx_bitn <= rx_bitn + 4'h1;
						if (rx_bitn == nbits - 4'h1)
							rx_state <= par_en ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					if (rx_samp) begin
						rx_perr  <= rxd_sync ^ rx_par ^ par_odd;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_samp) begin
						rx_fe <= ~rxd_sync;
						if (!par_en)
							rx_perr <= 1'b0;
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Pending third level and overrun; a new event wins over the clear
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pend  <= 1'b0;
			ovr_flag <= 1'b0;
		end else begin
			rx_pend  <= rx_done | (rx_pend & ~rx_push & ~rx_drop);
			ovr_flag <= rx_drop | (ovr_flag & ~rx_push);
		end
	end

	always @(posedge sys_clk) begin
		if (rx_push)
			fifo_mem[fifo_wp] <= {ovr_flag, rx_fe, rx_perr, rx_data};
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_wp  <= {FIFO_AW{1'b0}};
			fifo_rp  <= {FIFO_AW{1'b0}};
			fifo_cnt <= {(FIFO_AW+1){1'b0}};
		end else begin
			if (rx_push)
				fifo_wp <= fifo_wp + {{(FIFO_AW-1){1'b0}}, 1'b1};
			if (rx_pop)
				fifo_rp <= fifo_rp + {{(FIFO_AW-1){1'b0}}, 1'b1};
			if (rx_push && !rx_pop)
				fifo_cnt <= fifo_cnt + {{FIFO_AW{1'b0}}, 1'b1};
			else if (rx_pop && !rx_push)
				fifo_cnt <= fifo_cnt - {{FIFO_AW{1'b0}}, 1'b1};
		end
	end

	// Read port; status shows the head entry, lost once the data is read
	reg [7:0] rd_mux;

	always @* begin
		rd_mux = 8'h00;
		case (reg_addr)
			`UCF_ADDR_DATA: rd_mux = head[7:0];
			`UCF_ADDR_CSA: begin
				rd_mux[`UCF_A_RXC] = ~fifo_empty;
				rd_mux[`UCF_A_TXE] = ~tx_full;
				rd_mux[`UCF_A_FE]  = head[`UCF_E_FE];
				rd_mux[`UCF_A_DOR] = head[`UCF_E_DOR];
				rd_mux[`UCF_A_PE]  = head[`UCF_E_PE];
				rd_mux[`UCF_A_U2X] = double_speed;
			end
			`UCF_ADDR_CSB: begin
				rd_mux[`UCF_B_RXEN] = rx_enable;
				rd_mux[`UCF_B_TXEN] = tx_enable;
				rd_mux[`UCF_B_CSZ2] = char_size[2];
				rd_mux[`UCF_B_RX9]  = head[`UCF_E_D9];
				rd_mux[`UCF_B_TX9]  = tx_ninth_bit;
			end
			`UCF_ADDR_CSC: begin
				rd_mux[`UCF_C_DIR]  = xfer_clock_pin_direction;
				rd_mux[`UCF_C_SYNC] = sync_mode_select;
				rd_mux[`UCF_C_PM_HI:`UCF_C_PM_LO] = parity_mode;
				rd_mux[`UCF_C_SBS]  = stop_bits_select;
				rd_mux[`UCF_C_CSZ_HI:`UCF_C_CSZ_LO] = char_size[1:0];
				rd_mux[`UCF_C_POL]  = clock_polarity;
			end
			`UCF_ADDR_BAUDL: rd_mux = baud_divisor_low;
			`UCF_ADDR_BAUDH: rd_mux = {4'h0, baud_divisor_high};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data stands one cycle only, zero otherwise
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 8'h00;
	end

endmodule // ucf_usart_clk_frame

`default_nettype wire

// ---- test/ucf_remote.sv ----
// Remote serial party: drives the receive line, samples the transmit line.
// Assumes the caller gives the bit time in system clocks.
`timescale 1ns/1ps
`default_nettype none
module ucf_remote (
	input  wire logic sys_clk,
	input  wire logic txd_pin,
	output var  logic rxd_pin,
	output var  logic xfer_clock_pin_in
);
	initial begin
		rxd_pin           = 1'b1; // Idle high
		xfer_clock_pin_in = 1'b0; // No slave clock from this party, held still
	end
	// Low start, then bits LSB first; caller ends on a high bit
	task automatic send(input logic [11:0] bits, input int n, input int bitc);
		rxd_pin <= 1'b0;
		repeat (bitc) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			rxd_pin <= bits[i];
			repeat (bitc) @(posedge sys_clk);
		end
	endtask
	// Samples mid-bit after the start edge
	task automatic recv(output logic [11:0] bits, input int n, input int bitc);
		int w;
		bits = 12'h000;
		w = 0;
		while (txd_pin !== 1'b0 && w < 5000) begin
			@(posedge sys_clk);
			w++;
		end
		repeat (bitc / 2) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			repeat (bitc) @(posedge sys_clk);
			bits[i] = txd_pin;
		end
	endtask
endmodule // ucf_remote
`default_nettype wire

// ---- test/ucf_usart_clk_frame_bench.sv ----
// Self-checking bench: register port tasks, remote party, frame and FIFO model.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module ucf_usart_clk_frame_bench;
	logic        sys_clk, rst_b, reg_wr, reg_rd, rxd_pin, txd_pin, xck_in, xck_out, xck_oe_n;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, a, d;
	logic [11:0] got, ex, mk;
	logic [1:0]  pm;
	logic [31:0] seed;
	logic [9:0]  q[$];
	int          err_count, cmp_count, n, i, k, cnt;
	ucf_usart_clk_frame u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
		.xfer_clock_pin_in(xck_in), .xfer_clock_pin_out(xck_out), .xfer_clock_pin_oe_n(xck_oe_n));
	ucf_remote u_far (.sys_clk(sys_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin), .xfer_clock_pin_in(xck_in));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Expected bits after start: data, parity, then high stops
	function automatic logic [11:0] frame(input logic [8:0] v, input int nb, input logic [1:0] p);
		logic [11:0] f;
		f = 12'hfff;
		for (int j = 0; j < nb; j++) f[j] = v[j];
		if (p[1]) f[nb] = ^(v & ((9'h001 << nb) - 9'h001)) ^ p[0];
		return f;
	endfunction
	task automatic wr(input logic [2:0] ad, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr  <= ad;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] ad, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Status before data, since the data read drops the entry's status
	task automatic pop_chk;
		logic [9:0] e;
		e = q.pop_front();
		rd(3'h1, a);
		rd(3'h0, d);
		`CHK({a[3], a[4], d}, e)
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		err_count++;
		print_verdict;
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		err_count = 0;
		cmp_count = 0;
		seed = 32'h345e_ac87;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(3'h3, a);
		`CHK(a, 8'h06)
		for (i = 6; i < 8; i++) begin
			rd(i[2:0], a);
			`CHK(a, 8'h00)
		end
		$display("test registers done");
		wr(3'h5, 8'h00);
		wr(3'h4, 8'h01);
		for (i = 0; i < 5; i++) begin
			n = (i == 4) ? 9 : i + 5;
			k = (i == 4) ? 7 : i;
			pm = (i % 3 == 0) ? 2'h0 : ((i % 3 == 1) ? 2'h2 : 2'h3);
			seed = xs(seed);
			wr(3'h3, {2'b00, pm, i[0], k[1:0], 1'b0});
			wr(3'h2, {4'h0, 1'b1, k[2], 1'b0, seed[8]});
			wr(3'h0, seed[7:0]);
			u_far.recv(got, 12, 32);
			ex = frame(seed[8:0], n, pm);
			mk = (12'h001 << (n + pm[1] + 1 + i[0])) - 12'h001;
			`CHK(got & mk, ex & mk)
			repeat (32) @(posedge sys_clk);
		end
		// Double speed halves the bit time
		wr(3'h1, 8'h02);
		wr(3'h2, 8'h08);
		wr(3'h3, 8'h06);
		wr(3'h0, 8'h5a);
		u_far.recv(got, 9, 16);
		`CHK(got[8:0], 9'h15a)
		repeat (16) @(posedge sys_clk);
		wr(3'h1, 8'h00);
		$display("test transmit done");
		wr(3'h2, 8'h10);
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			u_far.send({2'b11, i != 7, seed[7:0]}, 10, 32);
			if (q.size() == 3) q[2] = {1'b1, i == 7, seed[7:0]};
			else q.push_back({1'b0, i == 7, seed[7:0]});
			if (i == 2 || i == 6 || i == 7) begin
				repeat (40) @(posedge sys_clk);
				while (q.size() > 0) pop_chk;
				rd(3'h1, a);
				`CHK(a[7], 1'b0)
			end
		end
		// Double speed receive, sampled on half as many ticks per bit
		wr(3'h1, 8'h02);
		seed = xs(seed);
		u_far.send({3'b111, seed[7:0]}, 10, 16);
		q.push_back({2'b00, seed[7:0]});
		repeat (40) @(posedge sys_clk);
		pop_chk;
		wr(3'h1, 8'h00);
		$display("test receive done");
		wr(3'h4, 8'h03);
		wr(3'h3, 8'hc0);
		repeat (4) @(posedge sys_clk);
		`CHK(xck_oe_n, 1'b0)
		cnt = 0;
		a[0] = xck_out;
		repeat (40) begin
			@(posedge sys_clk);
			if (xck_out !== a[0]) cnt++;
			a[0] = xck_out;
		end
		`CHK(cnt, 10)
		// Master transmit: data changes on rising, read back on falling
		wr(3'h2, 8'h08);
		wr(3'h0, 8'h15);
		k = 0;
		got = 12'h000;
		while (txd_pin !== 1'b0 && k < 400) begin
			@(negedge xck_out);
			k++;
		end
		for (i = 0; i < 6; i++) begin
			@(negedge xck_out);
			got[i] = txd_pin;
		end
		`CHK(got[5:0], 6'h35)
		wr(3'h3, 8'h41);
		repeat (3) @(posedge sys_clk);
		`CHK({xck_oe_n, xck_out}, 2'b11)
		$display("test clock modes done");
		print_verdict;
	end
endmodule // ucf_usart_clk_frame_bench
`default_nettype wire

// ---- test/ucf_usart_clk_frame_props.sv ----
// Checker for the serial clock and frame block, watching its ports only.
// Assumes control writes are visible on the register port and mirrored here.
`timescale 1ns/1ps
`default_nettype none
module ucf_checker (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       txd_pin,
	input wire logic       xfer_clock_pin_out,
	input wire logic       xfer_clock_pin_oe_n
);
	logic [7:0] sh_c;
	logic       tx_en;
	// Mirrors of control fields, since bodies are hidden
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sh_c  <= 8'h06;
			tx_en <= 1'b0;
		end else if (reg_wr && reg_addr == 3'h3) begin
			sh_c <= reg_wdata;
		end else if (reg_wr && reg_addr == 3'h2) begin
			tx_en <= reg_wdata[3];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	chk_reset_out: assert property ($rose(rst_b) |-> txd_pin && xfer_clock_pin_oe_n && !xfer_clock_pin_out)
		else $error("outputs wrong after reset");
	chk_oe_master: assert property (xfer_clock_pin_oe_n == !(sh_c[7] && sh_c[6]))
		else $error("clock pin enable wrong for mode");
	chk_xck_rest: assert property (!(sh_c[7] && sh_c[6]) && sh_c == $past(sh_c) |-> xfer_clock_pin_out == sh_c[0])
		else $error("clock pin not at polarity level");
	chk_tx_off_idle: assert property (!tx_en && !$past(tx_en) |-> txd_pin)
		else $error("transmit line not idle high");
	chk_bit_hold: assert property ($changed(txd_pin) && tx_en && !sh_c[6] |=> $stable(txd_pin) [*7])
		else $error("async bit shorter than eight cycles");
	chk_start_low: assert property ($fell(txd_pin) && tx_en && !sh_c[6] |-> !txd_pin [*8])
		else $error("start bit not held low");
	chk_csc_read: assert property ($past(reg_rd) && $past(reg_addr) == 3'h3 |-> reg_rdata == $past(sh_c))
		else $error("frame format readback wrong");
endmodule // ucf_checker
bind ucf_usart_clk_frame ucf_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd_pin(txd_pin),
	.xfer_clock_pin_out(xfer_clock_pin_out), .xfer_clock_pin_oe_n(xfer_clock_pin_oe_n));
`default_nettype wire
